// ### core/hrf_framer.v
// Notes on behaviour
// - characters are 8 data bits, no parity, one stop bit, no flow control.
// - the bit rate is measured from the host's own characters.
// - a colon starts a frame, and a colon at any point except during data replay restarts one.
// - after the colon each pair of ascii hex digits forms one byte.
// - the length byte counts the data bytes before the checksum.
// - the 16-bit load offset is flagged as used only for program records.
// - the record type byte is passed on to select the command.
// - an empty data field is accepted and yields a frame with no bytes.
// - the sum of length through checksum must be zero modulo 256.
`timescale 1ns/10ps
`include "hrf_map.vh"

module hrf_framer (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // serial line from the host
    input  wire        rxPin,
    // record header to the command logic
    output wire [7:0]  recLen,
    output wire [15:0] recOffset,
    output wire [7:0]  recType,
    output wire        offsetUsed,
    // record data stream
    output wire [7:0]  outByte,
    output wire        outValid,
    output wire        outLast,
    input  wire        outReady,
    // frame status
    output wire        frameDone,
    output wire        frameDrop,
    output wire        linkLocked
);

    localparam [3:0] ST_WAIT = 4'b0001;
    localparam [3:0] ST_HI   = 4'b0010;
    localparam [3:0] ST_LO   = 4'b0100;
    localparam [3:0] ST_EMIT = 4'b1000;

    wire [7:0] rxData;
    wire       rxValid;
    wire       rxFrameErr;

    reg [3:0]  state_reg;
    reg [2:0]  field_reg;
    reg [3:0]  hiNib_reg;
    reg [7:0]  sum_reg;
    reg [7:0]  len_reg;
    reg [7:0]  count_reg;
    reg [15:0] offset_reg;
    reg [7:0]  type_reg;
    reg [7:0]  holdLen_reg;
    reg [15:0] holdOffset_reg;
    reg [7:0]  holdType_reg;
    reg [7:0]  emitIdx_reg;
    reg [7:0]  outByte_reg;
    reg        done_reg;
    reg        drop_reg;
    reg [7:0]  buffer [0:255];

    // ------------------------------------------------------------
    // character receiver with autobaud
    // ------------------------------------------------------------
    hrf_uart_rx u_rx (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .rxPin      (rxPin),
        .rxData     (rxData),
        .rxValid    (rxValid),
        .rxFrameErr (rxFrameErr),
        .rxLocked   (linkLocked)
    );

    // ------------------------------------------------------------
    // hex digit decode: {valid, nibble}
    // ------------------------------------------------------------
    function [4:0] hexDigit;
        input [7:0] c;
        reg   [7:0] t;
        begin
            t = 8'h00;
            hexDigit = 5'h00;
            if (c >= `HRF_CHAR_0 && c <= `HRF_CHAR_9)
            begin
                t = c - `HRF_CHAR_0;
                hexDigit = {1'b1, t[3:0]};
            end
            else if (c >= `HRF_CHAR_UA && c <= `HRF_CHAR_UF)
            begin
                t = c - `HRF_CHAR_UA + `HRF_HEX_ALPHA_OFS;
                hexDigit = {1'b1, t[3:0]};
            end
            else if (c >= `HRF_CHAR_LA && c <= `HRF_CHAR_LF)
            begin
                t = c - `HRF_CHAR_LA + `HRF_HEX_ALPHA_OFS;
                hexDigit = {1'b1, t[3:0]};
            end
        end
    endfunction

    wire [4:0] digit    = hexDigit(rxData);
    wire [7:0] newByte  = {hiNib_reg, digit[3:0]};
    wire [7:0] newSum   = sum_reg + newByte;
    wire       isColon  = rxData == `HRF_CHAR_COLON;
    wire       emitTake = (state_reg == ST_EMIT) && outReady;
    wire       emitEnd  = emitIdx_reg == holdLen_reg - 1'b1;

    assign recLen     = holdLen_reg;
    assign recOffset  = holdOffset_reg;
    assign recType    = holdType_reg;
    assign offsetUsed = holdType_reg == `HRF_TYPE_PROGRAM;
    assign outByte    = outByte_reg;
    assign outValid   = state_reg == ST_EMIT;
    assign outLast    = outValid && emitEnd;
    assign frameDone  = done_reg;
    assign frameDrop  = drop_reg;

    // ------------------------------------------------------------
    // data bytes are held until the checksum proves the frame
    // ------------------------------------------------------------
    always @(posedge clk)
    begin
        if (rxValid && state_reg == ST_LO && digit[4]
            && field_reg == `HRF_FLD_DATA)
            buffer[count_reg] <= newByte;
    end

    // ------------------------------------------------------------
    // frame parser
    // ------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg      <= ST_WAIT;
            field_reg      <= `HRF_FLD_LEN;
            hiNib_reg      <= 4'h0;
            sum_reg        <= 8'h00;
            len_reg        <= 8'h00;
            count_reg      <= 8'h00;
            offset_reg     <= 16'h0000;
            type_reg       <= 8'h00;
            holdLen_reg    <= 8'h00;
            holdOffset_reg <= 16'h0000;
            holdType_reg   <= 8'h00;
            emitIdx_reg    <= 8'h00;
            outByte_reg    <= 8'h00;
            done_reg       <= 1'b0;
            drop_reg       <= 1'b0;
        end
        else
        begin
            done_reg <= 1'b0;
            drop_reg <= 1'b0;
            if (state_reg == ST_EMIT)
            begin
                // characters arriving during replay are ignored
                if (emitTake)
                begin
                    if (emitEnd)
                    begin
                        done_reg  <= 1'b1;
                        state_reg <= ST_WAIT;
                    end
                    else
                    begin
                        emitIdx_reg <= emitIdx_reg + 1'b1;
                        outByte_reg <= buffer[emitIdx_reg + 1'b1];
                    end
                end
            end
            else if (rxFrameErr)
            begin
                if (state_reg != ST_WAIT)
                    drop_reg <= 1'b1;
                state_reg <= ST_WAIT;
            end
            else if (rxValid)
            begin
                if (isColon)
                begin
                    if (state_reg != ST_WAIT)
                        drop_reg <= 1'b1;
                    state_reg <= ST_HI;
                    field_reg <= `HRF_FLD_LEN;
                    sum_reg   <= 8'h00;
                    count_reg <= 8'h00;
                end
                else if (state_reg == ST_WAIT)
                    state_reg <= ST_WAIT;
                else if (!digit[4])
                begin
                    drop_reg  <= 1'b1;
                    state_reg <= ST_WAIT;
                end
                else if (state_reg == ST_HI)
                begin
                    hiNib_reg <= digit[3:0];
                    state_reg <= ST_LO;
                end
                else
                begin
                    sum_reg   <= newSum;
                    state_reg <= ST_HI;
                    case (field_reg)
                        `HRF_FLD_LEN:
                        begin
                            len_reg   <= newByte;
                            field_reg <= `HRF_FLD_OFFH;
                        end
                        `HRF_FLD_OFFH:
                        begin
                            offset_reg[15:8] <= newByte;
                            field_reg        <= `HRF_FLD_OFFL;
                        end
                        `HRF_FLD_OFFL:
                        begin
                            offset_reg[7:0] <= newByte;
                            field_reg       <= `HRF_FLD_TYPE;
                        end
                        `HRF_FLD_TYPE:
                        begin
                            type_reg  <= newByte;
                            field_reg <= (len_reg == 8'h00) ?
                                         `HRF_FLD_SUM : `HRF_FLD_DATA;
                        end
                        `HRF_FLD_DATA:
                        begin
                            count_reg <= count_reg + 1'b1;
                            if (count_reg == len_reg - 1'b1)
                                field_reg <= `HRF_FLD_SUM;
                        end
                        `HRF_FLD_SUM:
                        begin
                            if (newSum == 8'h00)
                            begin
                                holdLen_reg    <= len_reg;
                                holdOffset_reg <= offset_reg;
                                holdType_reg   <= type_reg;
                                emitIdx_reg    <= 8'h00;
                                outByte_reg    <= buffer[0];
                                if (len_reg == 8'h00)
                                begin
                                    done_reg  <= 1'b1;
                                    state_reg <= ST_WAIT;
                                end
                                else
                                    state_reg <= ST_EMIT;
                            end
                            else
                            begin
                                drop_reg  <= 1'b1;
                                state_reg <= ST_WAIT;
                            end
                        end
                        default:
                            state_reg <= ST_WAIT;
                    endcase
                end
            end
        end
    end

endmodule

// ### core/hrf_map.vh
`ifndef HRF_MAP_VH
`define HRF_MAP_VH

// ----------------------------------------------------------------
// character codes
// ----------------------------------------------------------------
`define HRF_CHAR_COLON    8'h3A
`define HRF_CHAR_0        8'h30
`define HRF_CHAR_9        8'h39
`define HRF_CHAR_UA       8'h41
`define HRF_CHAR_UF       8'h46
`define HRF_CHAR_LA       8'h61
`define HRF_CHAR_LF       8'h66
`define HRF_HEX_ALPHA_OFS 8'h0A

// ----------------------------------------------------------------
// record types
// ----------------------------------------------------------------
`define HRF_TYPE_PROGRAM  8'h00

// ----------------------------------------------------------------
// serial timing
// ----------------------------------------------------------------
`define HRF_CNT_W         20
`define HRF_CNT_MAX       20'hF_FFFF
`define HRF_MIN_BIT       20'h0_0008
`define HRF_DATA_BITS     3'h7

// ----------------------------------------------------------------
// field sequence
// ----------------------------------------------------------------
`define HRF_FLD_LEN       3'h0
`define HRF_FLD_OFFH      3'h1
`define HRF_FLD_OFFL      3'h2
`define HRF_FLD_TYPE      3'h3
`define HRF_FLD_DATA      3'h4
`define HRF_FLD_SUM       3'h5

`endif

// ### core/hrf_uart_rx.v
`timescale 1ns/10ps
`include "hrf_map.vh"

module hrf_uart_rx (
    // clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // serial line from the host
    input  wire        rxPin,
    // received characters
    output wire [7:0]  rxData,
    output wire        rxValid,
    output wire        rxFrameErr,
    output wire        rxLocked
);

    localparam [5:0] RX_HUNT  = 6'b00_0001;
    localparam [5:0] RX_MEAS  = 6'b00_0010;
    localparam [5:0] RX_IDLE  = 6'b00_0100;
    localparam [5:0] RX_START = 6'b00_1000;
    localparam [5:0] RX_DATA  = 6'b01_0000;
    localparam [5:0] RX_STOP  = 6'b10_0000;

    reg [2:0]              syncPipe_reg;
    reg                    lineLevel_reg;
    reg                    linePrev_reg;
    reg [5:0]              state_reg;
    reg [`HRF_CNT_W-1:0]   cnt_reg;
    reg [`HRF_CNT_W-1:0]   bitLen_reg;
    reg [2:0]              bitIdx_reg;
    reg [7:0]              shift_reg;
    reg [7:0]              data_reg;
    reg                    valid_reg;
    reg                    frameErr_reg;
    reg                    locked_reg;
    reg                    calib_reg;

    wire fallEdge = linePrev_reg & ~lineLevel_reg;
    wire riseEdge = ~linePrev_reg & lineLevel_reg;
    wire [`HRF_CNT_W-1:0] halfBit = {1'b0, bitLen_reg[`HRF_CNT_W-1:1]};

    assign rxData     = data_reg;
    assign rxValid    = valid_reg;
    assign rxFrameErr = frameErr_reg;
    assign rxLocked   = locked_reg;

    // ------------------------------------------------------------
    // line synchroniser: level changes once stages two and three agree
    // ------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            syncPipe_reg  <= 3'h7;
            lineLevel_reg <= 1'b1;
            linePrev_reg  <= 1'b1;
        end
        else
        begin
            syncPipe_reg <= {syncPipe_reg[1:0], rxPin};
            linePrev_reg <= lineLevel_reg;
            if (syncPipe_reg[1] == syncPipe_reg[2])
                lineLevel_reg <= syncPipe_reg[2];
        end
    end

    // ------------------------------------------------------------
    // autobaud and 8N1 character receiver
    // ------------------------------------------------------------
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_reg    <= RX_HUNT;
            cnt_reg      <= {`HRF_CNT_W{1'b0}};
            bitLen_reg   <= {`HRF_CNT_W{1'b0}};
            bitIdx_reg   <= 3'h0;
            shift_reg    <= 8'h00;
            data_reg     <= 8'h00;
            valid_reg    <= 1'b0;
            frameErr_reg <= 1'b0;
            locked_reg   <= 1'b0;
            calib_reg    <= 1'b0;
        end
        else
        begin
            valid_reg    <= 1'b0;
            frameErr_reg <= 1'b0;
            if (cnt_reg != {`HRF_CNT_W{1'b0}} && state_reg != RX_MEAS)
                cnt_reg <= cnt_reg - 1'b1;
            case (state_reg)
                RX_HUNT:
                begin
                    locked_reg <= 1'b0;
                    if (fallEdge)
                    begin
                        cnt_reg   <= {{(`HRF_CNT_W-1){1'b0}}, 1'b1};
                        state_reg <= RX_MEAS;
                    end
                end
                // bit rate from start plus bit0
                // the colon keeps the line low for start bit and bit 0,
                // so half the low time is one bit; the edge cycle is low too
                RX_MEAS:
                begin
                    if (cnt_reg != `HRF_CNT_MAX)
                        cnt_reg <= cnt_reg + 1'b1;
                    else
                        state_reg <= RX_HUNT;
                    if (riseEdge)
                    begin
                        if (cnt_reg[`HRF_CNT_W-1:1] >= `HRF_MIN_BIT)
                        begin
                            bitLen_reg <= {1'b0, cnt_reg[`HRF_CNT_W-1:1]};
                            cnt_reg    <= {2'b00, cnt_reg[`HRF_CNT_W-1:2]};
                            shift_reg  <= 8'h00;
                            bitIdx_reg <= 3'h1;
                            calib_reg  <= 1'b1;
                            state_reg  <= RX_DATA;
                        end
                        else
                            state_reg <= RX_HUNT;
                    end
                end
                RX_IDLE:
                begin
                    if (fallEdge)
                    begin
                        cnt_reg   <= halfBit;
                        state_reg <= RX_START;
                    end
                end
                RX_START:
                begin
                    if (cnt_reg == {`HRF_CNT_W{1'b0}})
                    begin
                        cnt_reg    <= bitLen_reg - 1'b1;
                        bitIdx_reg <= 3'h0;
                        state_reg  <= lineLevel_reg ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA:
                begin
                    if (cnt_reg == {`HRF_CNT_W{1'b0}})
                    begin
                        shift_reg  <= {lineLevel_reg, shift_reg[7:1]};
                        cnt_reg    <= bitLen_reg - 1'b1;
                        bitIdx_reg <= bitIdx_reg + 1'b1;
                        if (bitIdx_reg == `HRF_DATA_BITS)
                            state_reg <= RX_STOP;
                    end
                end
                RX_STOP:
                begin
                    if (cnt_reg == {`HRF_CNT_W{1'b0}})
                    begin
                        calib_reg <= 1'b0;
                        if (lineLevel_reg)
                        begin
                            valid_reg <= 1'b1;
                            data_reg  <= shift_reg;
                            // a bad calibration character forces a remeasure
                            if (calib_reg && shift_reg != `HRF_CHAR_COLON)
                                state_reg <= RX_HUNT;
                            else
                            begin
                                locked_reg <= 1'b1;
                                state_reg  <= RX_IDLE;
                            end
                        end
                        else
                        begin
                            frameErr_reg <= 1'b1;
                            state_reg    <= RX_HUNT;
                        end
                    end
                end
                default:
                    state_reg <= RX_HUNT;
            endcase
        end
    end

endmodule

// ### dv/hrf_framer_monitor.sv
`timescale 1ns/10ps

module hrf_framer_monitor (
    // clock and reset
    input logic        clk,
    input logic        sys_rst,
    // serial line
    input logic        rxPin,
    // record header
    input logic [7:0]  recLen,
    input logic [15:0] recOffset,
    input logic [7:0]  recType,
    input logic        offsetUsed,
    // data stream
    input logic [7:0]  outByte,
    input logic        outValid,
    input logic        outLast,
    input logic        outReady,
    // status
    input logic        frameDone,
    input logic        frameDrop,
    input logic        linkLocked
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [8:0] takenCnt_reg;

    default clocking mcb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // bytes handed over so far in the current replay
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            takenCnt_reg <= 9'h000;
        else if (outValid && outReady)
            takenCnt_reg <= outLast ? 9'h000 : takenCnt_reg + 9'h001;
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    a_offset_used: assert property (
        offsetUsed == (recType == 8'h00))
        else $error("offset flag disagrees with record type");
    a_done_pulse: assert property (
        frameDone |=> !frameDone && !outValid)
        else $error("done pulse too long or data after done");
    a_drop_clean: assert property (
        frameDrop |-> (!frameDone && !outValid) ##1 !frameDrop)
        else $error("dropped frame reached the data side");
    a_last_valid: assert property (
        outLast |-> outValid)
        else $error("last flag without valid");
    a_byte_hold: assert property (
        outValid && !outReady |=> outValid && $stable(outByte)
            && $stable(outLast))
        else $error("offered byte changed before it was taken");
    a_last_done: assert property (
        outValid && outReady && outLast |=> frameDone)
        else $error("no done pulse after last byte");
    a_byte_count: assert property (
        outValid && outReady && outLast |->
            takenCnt_reg + 9'h001 == {1'b0, recLen})
        else $error("delivered byte count differs from length");
    a_hdr_steady: assert property (
        outValid ##1 outValid |-> $stable(recLen) && $stable(recOffset)
            && $stable(recType))
        else $error("header moved during data replay");
    a_done_locked: assert property (
        frameDone |-> linkLocked)
        else $error("frame done without a locked link");
    a_empty_done: assert property (
        frameDone && !$past(outValid) |-> recLen == 8'h00)
        else $error("done without data on a non-empty frame");
endmodule

bind hrf_framer hrf_framer_monitor hrf_framer_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .rxPin(rxPin), .recLen(recLen),
    .recOffset(recOffset), .recType(recType), .offsetUsed(offsetUsed),
    .outByte(outByte), .outValid(outValid), .outLast(outLast),
    .outReady(outReady), .frameDone(frameDone), .frameDrop(frameDrop),
    .linkLocked(linkLocked)
);

// ### dv/hrf_framer_tb.sv
`timescale 1ns/10ps

module hrf_framer_tb;
    // ------------------------------------------------------------
    // signals and cases
    // ------------------------------------------------------------
    logic        clk;
    logic        sys_rst;
    logic        rxPin;
    logic [7:0]  recLen;
    logic [15:0] recOffset;
    logic [7:0]  recType;
    logic        offsetUsed;
    logic [7:0]  outByte;
    logic        outValid;
    logic        outLast;
    logic        outReady;
    logic        frameDone;
    logic        frameDrop;
    logic        linkLocked;
    int          errors;
    int          n_compared;
    int          doneCnt = 0;
    int          dropCnt = 0;
    int          dr;

    typedef struct packed {
        logic [7:0]  len;
        logic [15:0] off;
        logic [7:0]  typ;
        logic [15:0] dat;
        logic        lc;
    } hrf_row_t;

    hrf_row_t rows [4] = '{
        '{8'h00, 16'h0000, 8'h01, 16'h0000, 1'b0},
        '{8'h01, 16'h1234, 8'h00, 16'hAB00, 1'b0},
        '{8'h02, 16'hFFFF, 8'h00, 16'h5AC3, 1'b1},
        '{8'h02, 16'h0000, 8'h02, 16'h00FF, 1'b0}
    };

    hrf_framer hrf_framer_inst (
        .clk(clk), .sys_rst(sys_rst), .rxPin(rxPin), .recLen(recLen),
        .recOffset(recOffset), .recType(recType), .offsetUsed(offsetUsed),
        .outByte(outByte), .outValid(outValid), .outLast(outLast),
        .outReady(outReady), .frameDone(frameDone), .frameDrop(frameDrop),
        .linkLocked(linkLocked)
    );

    hrf_host_model hrf_host_model_inst (.clk(clk), .txLine(rxPin));

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // pulses are counted here so none is missed while the host sends
    always @(posedge clk)
    begin
        if (frameDone === 1'b1)
            doneCnt <= doneCnt + 1;
        if (frameDrop === 1'b1)
            dropCnt <= dropCnt + 1;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic checkVal(input logic [15:0] got, input logic [15:0] exp,
                            input string what);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %0t: %0s %h /= %h", $time, what, got, exp);
        end
    endtask

    task automatic checkCnt(input int got, input int exp, input string what);
        n_compared++;
        if (got != exp)
        begin
            errors++;
            $display("CHECK FAILED %0t: %0s %0d /= %0d", $time, what, got,
                     exp);
        end
    endtask

    task automatic end_of_test;
        $display("compared %0d, mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic waitValid;
        int n;
        n = 0;
        while (outValid !== 1'b1)
        begin
            n++;
            if (n > 2000)
            begin
                checkCnt(n, 0, "valid wait ran out");
                end_of_test;
            end
            tick(1);
        end
    endtask

    task automatic sendPrefix(input logic [7:0] c, input logic badStop);
        hrf_host_model_inst.sendChar(8'h3A, 1'b0);
        hrf_host_model_inst.sendChar(8'h30, 1'b0);
        hrf_host_model_inst.sendChar(c, badStop);
    endtask

    task automatic runRow(input hrf_row_t r, input logic stall);
        int         d0;
        logic [7:0] b;
        d0 = doneCnt;
        hrf_host_model_inst.sendFrame(r.len, r.off, r.typ, r.dat, r.lc,
                                      8'h00);
        for (int i = 0; i < r.len; i++)
        begin
            waitValid();
            if (stall && i == 0)
                tick(5);
            b = (i == 0) ? r.dat[15:8] : r.dat[7:0];
            checkVal(outByte, b, "data");
            checkVal(outLast, i == r.len - 1, "last");
            outReady = 1'b1;
            tick(1);
        end
        outReady = 1'b0;
        tick(3);
        checkCnt(doneCnt, d0 + 1, "done");
        checkVal(recLen, r.len, "length");
        checkVal(recOffset, r.off, "offset");
        checkVal(recType, r.typ, "type");
        checkVal(offsetUsed, r.typ == 8'h00, "offset used");
        $display("test frame len %0d type %h done", r.len, r.typ);
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial
    begin
        errors = 0;
        n_compared = 0;
        sys_rst = 1'b1;
        outReady = 1'b0;
        tick(7);
        checkVal(outValid, 1'b0, "valid in reset");
        checkVal(linkLocked, 1'b0, "lock in reset");
        tick(1);
        sys_rst = 1'b0;
        tick(4);
        foreach (rows[i])
            runRow(rows[i], 1'b0);
        checkCnt(dropCnt, 0, "good frames kept");
        runRow(rows[1], 1'b1);
        dr = dropCnt;
        hrf_host_model_inst.sendFrame(8'h02, 16'hFFFF, 8'h00, 16'h5AC3,
                                      1'b0, 8'h01);
        tick(4);
        checkCnt(dropCnt, dr + 1, "bad sum drop");
        checkVal(outValid, 1'b0, "bad sum data");
        checkVal(recOffset, 16'h1234, "kept offset");
        $display("test bad checksum done");
        dr = dropCnt;
        sendPrefix(8'h47, 1'b0);
        runRow(rows[3], 1'b0);
        checkCnt(dropCnt, dr + 1, "non-hex drop");
        dr = dropCnt;
        sendPrefix(8'h31, 1'b0);
        runRow(rows[2], 1'b0);
        checkCnt(dropCnt, dr + 1, "restart drop");
        dr = dropCnt;
        sendPrefix(8'h31, 1'b1);
        tick(2);
        checkVal(linkLocked, 1'b0, "unlock");
        checkCnt(dropCnt, dr + 1, "stop error drop");
        // a new rate after the error must be measured again
        hrf_host_model_inst.bitCycles = 24;
        runRow(rows[1], 1'b0);
        checkVal(linkLocked, 1'b1, "relock");
        $display("test stop error and new rate done");
        end_of_test;
    end
endmodule

// ### dv/hrf_host_model.sv
`timescale 1ns/10ps

module hrf_host_model (
    // clock
    input  logic clk,
    // serial line to the framer
    output logic txLine
);
    // ------------------------------------------------------------
    // character and frame sender
    // ------------------------------------------------------------
    int bitCycles = 16;

    initial txLine = 1'b1;

    task automatic bitOut(input logic v);
        txLine = v;
        repeat (bitCycles) @(posedge clk);
        #1;
    endtask

    // 8 data bits lsb first, one stop, no parity
    task automatic sendChar(input logic [7:0] c, input logic badStop);
        bitOut(1'b0);
        for (int i = 0; i < 8; i++)
            bitOut(c[i]);
        bitOut(~badStop);
        // two idle bits so a low stop bit never merges into a start edge
        bitOut(1'b1);
        bitOut(1'b1);
    endtask

    function automatic logic [7:0] hexChar(input logic [3:0] n,
                                           input logic lc);
        if (n < 4'hA)
            return 8'h30 + {4'h0, n};
        return (lc ? 8'h61 : 8'h41) + {4'h0, n} - 8'h0A;
    endfunction

    task automatic sendHex(input logic [7:0] b, input logic lc);
        sendChar(hexChar(b[7:4], lc), 1'b0);
        sendChar(hexChar(b[3:0], lc), 1'b0);
    endtask

    // colon, then fields in fixed order
    task automatic sendFrame(input logic [7:0] len, input logic [15:0] off,
        input logic [7:0] typ, input logic [15:0] dat, input logic lc,
        input logic [7:0] sumAdj);
        logic [7:0] sum;
        logic [7:0] b;
        sum = len + off[15:8] + off[7:0] + typ;
        sendChar(8'h3A, 1'b0);
        sendHex(len, lc);
        sendHex(off[15:8], lc);
        sendHex(off[7:0], lc);
        sendHex(typ, lc);
        for (int i = 0; i < len; i++)
        begin
            b = (i == 0) ? dat[15:8] : dat[7:0];
            sum = sum + b;
            sendHex(b, lc);
        end
        // two's complement, sumAdj spoils it on purpose
        sendHex(8'h00 - sum + sumAdj, lc);
    endtask
endmodule
